/* verilog/svrw_regs.svh */
// Constants for the supervisor: clock, timing, register map and fields
`ifndef SVRW_REGS_SVH
`define SVRW_REGS_SVH

// System clock rate in MHz
`define SVRW_CLK_MHZ        125
// Reset hold time after the cause clears, in ms
`define SVRW_RST_TIMEOUT_MS 200
// Watchdog timeout, in ms (1.6 s)
`define SVRW_WDG_TIMEOUT_MS 1600
// Delay from reset to chip-enable gate off, in us
`define SVRW_CE_DELAY_US    28
// Derived cycle counts
`define SVRW_RST_CYC (`SVRW_RST_TIMEOUT_MS * 1000 * `SVRW_CLK_MHZ)
`define SVRW_WDG_CYC (`SVRW_WDG_TIMEOUT_MS * 1000 * `SVRW_CLK_MHZ)
`define SVRW_CE_CYC  (`SVRW_CE_DELAY_US * `SVRW_CLK_MHZ)

// Register offsets
`define SVRW_CTRL_OFF   4'h0
`define SVRW_STATUS_OFF 4'h4
// Control fields and reset value
`define SVRW_CTRL_WDG_EN 0
`define SVRW_CTRL_RST    1'h1
// Status fields
`define SVRW_ST_RESET_N  0
`define SVRW_ST_FAULT_N  1
`define SVRW_ST_BACKUP   2
`define SVRW_ST_CELL_OK  3
`define SVRW_ST_WARN_N   4
`define SVRW_ST_GATE_EN  5

// Synchroniser reset image: supply low, reset pin high, enable high
`define SVRW_SYNC_INIT 9'h143

`endif

/* verilog/svrw_pkg.sv */
// Types shared by the supervisor design
`default_nettype none
package svrw_pkg;
    // Reset sequencer states, one-hot
    typedef enum logic [2:0] {
        SVRW_HOLD    = 3'h1,
        SVRW_TIMEOUT = 3'h2,
        SVRW_RUN     = 3'h4
    } svrw_state_t;

    // Analog comparator results arriving as logic
    typedef struct packed {
        logic below_rst;   // Supply below reset threshold
        logic below_backup_cell_supply;  // Supply below battery voltage
        logic low_line;    // Supply within low-line band
        logic cell_above;  // Battery above good threshold
        logic ge_4v;       // Supply at or above 4 V
        logic kick_open;   // Kick input left open
    } svrw_cmp_t;

    // Long timer counter
    typedef logic [27:0] svrw_cnt_t;
endpackage
`default_nettype wire

/* verilog/svrw_top.sv */
// Supervisor: reset sequencer, watchdog, chip-enable gate, backup status
//
// How it works
// - Manual reset low holds reset, plus 200ms
// - Low supply or manual reset drive reset
// - Active-high reset mirrors active-low reset
// - Supply dip restarts the reset timeout
// - Low-line condition drives warning output low
// - Kick edge or reset clears watchdog
// - Kick stuck past 1.6s drives fault low
// - Watchdog counter held cleared during reset
// - Watchdog off on low supply or open kick
// - Fault output high throughout reset
// - Gate passes enable while out of reset
// - Power-down: gate closes 28us after reset
// - Power-up: gate closed until reset ends
// - Closed gate drives enable output high
// - Battery selected only below both thresholds
// - Backup flag shows battery rail selection
// - Cell good when battery high, supply 4V
// - Open manual reset reads as high
// - Bouncing switch gives one reset
// - Backup mode ignores kick and manual reset
// - Backup mode below 4V forces cell good low
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "svrw_regs.svh"

module svrw_top #(
    // Cycle counts, shortened in simulation
    parameter int unsigned RST_CYC = `SVRW_RST_CYC,
    parameter int unsigned WDG_CYC = `SVRW_WDG_CYC
) (
    // Clock and reset
    input  wire logic                  i_mclk,
    input  wire logic                  i_nrst,
    // Comparator flags and pins
    input  wire svrw_pkg::svrw_cmp_t   i_cmp,
    input  wire logic                  i_watchdog_kick,
    input  wire logic                  i_manual_reset_n,
    input  wire logic                  i_chip_enable_in,
    // Register port
    input  wire logic [3:0]            i_addr,
    input  wire logic [31:0]           i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [31:0]           o_rdata,
    // Supervisor outputs
    output logic                       o_reset_n,
    output logic                       o_reset,
    output logic                       o_supply_low_warning_n,
    output logic                       o_watchdog_fault_n,
    output logic                       o_chip_enable_gated,
    output logic                       o_backup_active,
    output logic                       o_backup_cell_good
);
    import svrw_pkg::*;

    // Last count of each timer
    localparam svrw_cnt_t  RST_LAST = svrw_cnt_t'(RST_CYC - 1);
    localparam svrw_cnt_t  WDG_LAST = svrw_cnt_t'(WDG_CYC - 1);
    localparam logic [11:0] CE_LAST = 12'(`SVRW_CE_CYC - 1);

    // Address match, shared by read and write decode
    function automatic logic addr_hit(input logic [3:0] a,
                                      input logic [3:0] off);
        addr_hit = (a == off);
    endfunction

    // Synchroniser stages
    logic [8:0]  sync1_q;       // First stage, read by stage two only
    logic [8:0]  sync2_q;       // Safe to use
    // Synchronised views
    svrw_cmp_t   cmp_s;         // Comparator flags
    logic        kick_s;        // Kick level
    logic        mr_n_s;        // Manual reset level
    logic        ce_s;          // Chip-enable input level
    // Reset sequencer
    svrw_state_t state_q;       // Sequencer state
    svrw_state_t state_d;
    svrw_cnt_t   rst_cnt_q;     // Timeout counter
    svrw_cnt_t   rst_cnt_d;
    logic        rst_cond;      // Some cause holds reset
    logic        rst_on_q;      // Reset asserted now
    logic        rst_on_d;
    // Mode decode
    logic        backup;        // Battery-backup mode
    logic        mr_low;        // Manual reset honoured low
    // Watchdog
    logic        kick_prev_q;   // Kick level last cycle
    logic        kick_edge;     // Either edge on kick
    logic        wdg_dis;       // Watchdog disabled
    svrw_cnt_t   wdg_cnt_q;     // Watchdog counter
    svrw_cnt_t   wdg_cnt_d;
    logic        fault_n_d;     // Next fault output
    // Chip-enable gate
    logic        gate_en_q;     // Gate open
    logic        gate_en_d;
    logic [11:0] ce_cnt_q;      // Power-down delay counter
    logic [11:0] ce_cnt_d;
    // Register file
    logic        wdg_en_q;      // Software watchdog enable
    logic [31:0] status;        // Status word
    logic [31:0] rd_mux;        // Read selection

    // Two-flop synchroniser; reset image reads manual reset high
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1_q <= `SVRW_SYNC_INIT;
            sync2_q <= `SVRW_SYNC_INIT;
        end else begin
            sync1_q <= {i_cmp, i_watchdog_kick, i_manual_reset_n,
                        i_chip_enable_in};
            sync2_q <= sync1_q;
        end
    end
    // Unpack synchronised inputs
    assign cmp_s  = svrw_cmp_t'(sync2_q[8:3]);
    assign kick_s = sync2_q[2];
    assign mr_n_s = sync2_q[1];
    assign ce_s   = sync2_q[0];
    // Backup only when below reset threshold and battery
    assign backup = cmp_s.below_rst & cmp_s.below_backup_cell_supply;
    // Manual reset is ignored in backup mode
    assign mr_low = ~mr_n_s & ~backup;
    // Any cause of reset
    assign rst_cond = cmp_s.below_rst | mr_low;
    // Sequencer next state; any bounce restarts the hold
    always_comb begin
        state_d = state_q;
        case (state_q)
            SVRW_HOLD: begin
                // Leave once every cause clears
                state_d = rst_cond ? SVRW_HOLD : SVRW_TIMEOUT;
            end
            SVRW_TIMEOUT: begin
                if (rst_cond) begin
                    // Fresh dip restarts from zero
                    state_d = SVRW_HOLD;
                end else if (rst_cnt_q == RST_LAST) begin
                    state_d = SVRW_RUN;
                end else begin
                    state_d = SVRW_TIMEOUT;
                end
            end
            SVRW_RUN: begin
                state_d = rst_cond ? SVRW_HOLD : SVRW_RUN;
            end
            default: begin
                // Illegal code falls back to reset
                state_d = SVRW_HOLD;
            end
        endcase
    end
    // Count only while timing out
    assign rst_cnt_d = (state_q == SVRW_TIMEOUT && !rst_cond)
                     ? rst_cnt_q + 28'h0000001 : '0;
    assign rst_on_d  = (state_d != SVRW_RUN);
    // Sequencer registers; power-on starts in reset
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q   <= SVRW_HOLD;
            rst_cnt_q <= '0;
            rst_on_q  <= 1'h1;
        end else begin
            state_q   <= state_d;
            rst_cnt_q <= rst_cnt_d;
            rst_on_q  <= rst_on_d;
        end
    end
    // Watchdog: edge detect on the synchronised level
    assign kick_edge = kick_s ^ kick_prev_q;
    // Disabled on low supply, open kick, backup or by software
    assign wdg_dis = cmp_s.below_rst | cmp_s.kick_open
                   | backup | ~wdg_en_q;
    // Watchdog next values
    always_comb begin
        wdg_cnt_d = wdg_cnt_q + 28'h0000001;
        fault_n_d = o_watchdog_fault_n;
        if (rst_on_q || wdg_dis) begin
            // Held clear during reset or while disabled
            wdg_cnt_d = '0;
            fault_n_d = 1'h1;
        end else if (kick_edge) begin
            // Any edge restarts the timeout
            wdg_cnt_d = '0;
            fault_n_d = 1'h1;
        end else if (!o_watchdog_fault_n) begin
            // Fault stands until the next edge
            wdg_cnt_d = '0;
            fault_n_d = 1'h0;
        end else if (wdg_cnt_q == WDG_LAST) begin
            // Kick held one level too long
            wdg_cnt_d = '0;
            fault_n_d = 1'h0;
        end
    end
    // Watchdog registers
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            kick_prev_q        <= 1'h0;
            wdg_cnt_q          <= '0;
            o_watchdog_fault_n <= 1'h1;
        end else begin
            kick_prev_q        <= kick_s;
            wdg_cnt_q          <= wdg_cnt_d;
            o_watchdog_fault_n <= fault_n_d;
        end
    end
    // Gate delay counts from the reset edge while still open
    assign ce_cnt_d = (rst_on_q && gate_en_q) ? ce_cnt_q + 12'h001 : '0;
    // Gate open/close decision
    always_comb begin
        if (!rst_on_d) begin
            // Out of reset: pass every transition
            gate_en_d = 1'h1;
        end else if (!rst_on_q) begin
            // Reset just asserting: supply loss keeps it open a while
            gate_en_d = cmp_s.below_rst & ~mr_low;
        end else begin
            // Close after the delay; never reopen inside reset
            gate_en_d = gate_en_q && (ce_cnt_q != CE_LAST);
        end
    end
    // Gate registers; closed from power-on
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            gate_en_q <= 1'h0;
            ce_cnt_q  <= '0;
        end else begin
            gate_en_q <= gate_en_d;
            ce_cnt_q  <= ce_cnt_d;
        end
    end
    // Supervisor outputs, all registered
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reset_n              <= 1'h0;
            o_reset                <= 1'h1;
            o_supply_low_warning_n <= 1'h0;
            o_chip_enable_gated    <= 1'h1;
            o_backup_active        <= 1'h0;
            o_backup_cell_good     <= 1'h0;
        end else begin
            o_reset_n <= ~rst_on_d;
            o_reset   <= rst_on_d;
            // Warning also low in backup mode
            o_supply_low_warning_n <= ~(cmp_s.low_line | backup);
            // Inactive high whenever the gate is closed
            o_chip_enable_gated <= gate_en_q ? ce_s : 1'h1;
            o_backup_active     <= backup;
            // Only trusted with supply at or above 4 V
            o_backup_cell_good  <= cmp_s.cell_above & cmp_s.ge_4v;
        end
    end
    // Register port: control write
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            wdg_en_q <= `SVRW_CTRL_RST;
        end else if (i_wr && addr_hit(i_addr, `SVRW_CTRL_OFF)) begin
            wdg_en_q <= i_wdata[`SVRW_CTRL_WDG_EN];
        end
    end
    // Status word shows live block state
    always_comb begin
        status = '0;
        status[`SVRW_ST_RESET_N] = o_reset_n;
        status[`SVRW_ST_FAULT_N] = o_watchdog_fault_n;
        status[`SVRW_ST_BACKUP]  = o_backup_active;
        status[`SVRW_ST_CELL_OK] = o_backup_cell_good;
        status[`SVRW_ST_WARN_N]  = o_supply_low_warning_n;
        status[`SVRW_ST_GATE_EN] = gate_en_q;
    end
    // Read select; unmapped addresses read zero
    assign rd_mux = addr_hit(i_addr, `SVRW_CTRL_OFF)
                  ? {31'h00000000, wdg_en_q}
                  : addr_hit(i_addr, `SVRW_STATUS_OFF) ? status : '0;
    // Read data valid only in the cycle after the strobe
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= i_rd ? rd_mux : '0;
        end
    end
    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    property p_rst_inverse;
        o_reset == !o_reset_n;
    endproperty
    a_rst_inverse: assert property (p_rst_inverse)
        else $error("active-high reset not inverse");
    property p_cause_resets;
        rst_cond |=> !o_reset_n ##1 !o_reset_n;
    endproperty
    a_cause_resets: assert property (p_cause_resets)
        else $error("reset cause did not assert reset");
    property p_release_after_timeout;
        $rose(o_reset_n) |-> $past(rst_cnt_q) == RST_LAST
                             && $past(state_q) == SVRW_TIMEOUT;
    endproperty
    a_release_after_timeout: assert property (p_release_after_timeout)
        else $error("reset released before full timeout");
    property p_dip_restarts;
        (state_q == SVRW_TIMEOUT && rst_cond) |=> rst_cnt_q == '0
                                               && state_q == SVRW_HOLD;
    endproperty
    a_dip_restarts: assert property (p_dip_restarts)
        else $error("timeout not restarted on dip");
    property p_warn_low;
        cmp_s.low_line |=> !o_supply_low_warning_n;
    endproperty
    a_warn_low: assert property (p_warn_low)
        else $error("low-line warning missing");
    property p_kick_clears;
        (kick_edge && !rst_on_q) |=> o_watchdog_fault_n && wdg_cnt_q == '0;
    endproperty
    a_kick_clears: assert property (p_kick_clears)
        else $error("kick edge did not clear watchdog");
    property p_fault_fires;
        (wdg_cnt_q == WDG_LAST && !rst_on_q && !wdg_dis && !kick_edge
         && o_watchdog_fault_n) |=> !o_watchdog_fault_n;
    endproperty
    a_fault_fires: assert property (p_fault_fires)
        else $error("watchdog did not fire at timeout");
    property p_cnt_held;
        rst_on_q |=> wdg_cnt_q == '0;
    endproperty
    a_cnt_held: assert property (p_cnt_held)
        else $error("watchdog counted during reset");
    property p_fault_high_in_rst;
        (rst_on_q || wdg_dis) |=> o_watchdog_fault_n;
    endproperty
    a_fault_high_in_rst: assert property (p_fault_high_in_rst)
        else $error("fault low during reset or disable");
    // A release landing on the last delay cycle legitimately reopens
    property p_gate_delay;
        (gate_en_q && rst_on_q && rst_on_d && ce_cnt_q == CE_LAST) |=> !gate_en_q;
    endproperty
    a_gate_delay: assert property (p_gate_delay)
        else $error("gate not closed after delay");
    property p_closed_high;
        !gate_en_q |=> o_chip_enable_gated;
    endproperty
    a_closed_high: assert property (p_closed_high)
        else $error("closed gate passed enable");
    property p_backup_flag;
        backup |=> o_backup_active && !o_supply_low_warning_n;
    endproperty
    a_backup_flag: assert property (p_backup_flag)
        else $error("backup mode not flagged");
    property p_cell_low;
        !cmp_s.ge_4v |=> !o_backup_cell_good;
    endproperty
    a_cell_low: assert property (p_cell_low)
        else $error("cell good high below 4 V");
    // Main scenarios
    c_release: cover property ($rose(o_reset_n));
    c_fault: cover property ($fell(o_watchdog_fault_n));
    c_gate_close: cover property ($fell(gate_en_q) && cmp_s.below_rst);
    c_backup: cover property ($rose(o_backup_active));
endmodule
`default_nettype wire

/* dv/svrw_cpu_model.sv */
// Processor and RAM side model: watchdog kicks, chip enable, reset switch
`timescale 1ns/1ps
`default_nettype none
module svrw_cpu_model #(
    parameter int unsigned GAP = 10
) (
    // Clock and supervisor outputs
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    input  wire logic i_fault_n,
    // Bench controls
    input  wire logic i_kick_run,
    input  wire logic i_slow,
    input  wire logic i_wire_fault,
    input  wire logic i_button_n,
    input  wire logic i_ce_drive,
    // Lines into the supervisor
    output logic      o_watchdog_kick,
    output logic      o_manual_reset_n,
    output logic      o_chip_enable_in
);
    int unsigned gap_q   = 0;    // Cycles since last kick
    logic        kick_q  = 1'b0; // Kick level
    logic        float_q = 1'b0; // Released enable line wanders

    // Firmware kicks only while it runs, slow mode doubles the gap
    always @(posedge i_mclk) begin
        float_q <= ~float_q;
        gap_q   <= gap_q + 1;
        if (i_kick_run && i_reset_n && gap_q >= (i_slow ? 2 * GAP : GAP)) begin
            kick_q <= ~kick_q;
            gap_q  <= 0;
        end
    end
    assign o_watchdog_kick  = kick_q;
    // Processor held in reset lets its enable line float
    assign o_chip_enable_in = i_reset_n ? i_ce_drive : float_q;
    // Fault diode-ORed onto the switch line, open switch reads high
    assign o_manual_reset_n = i_button_n & (i_fault_n | ~i_wire_fault);
endmodule
`default_nettype wire

/* dv/supervisor_reset_watchdog_ce_gate_tb_top.sv */
// Self-checking bench for the supervisor block
`timescale 1ns/1ps
`default_nettype none
module supervisor_reset_watchdog_ce_gate_tb_top;
    import svrw_pkg::*;
    localparam int unsigned RC = 20;   // Short reset timeout
    localparam int unsigned WC = 50;   // Short watchdog timeout
    localparam int unsigned CE = 3500; // Gate hold after supply loss
    // Design side signals
    logic        i_mclk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_wr   = 1'b0;
    logic        i_rd   = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [31:0] o_rdata;
    svrw_cmp_t   cmp = 6'h2E;          // Power-up: supply low, low line
    logic        kick, mr_n, ce_in, rst_n, rst, warn_n, fault_n, gated, bkp, cok;
    // Model controls
    logic        kick_run = 1'b0;
    logic        slow     = 1'b0;
    logic        wire_f   = 1'b0;
    logic        button_n = 1'b1;
    logic        ce_drive = 1'b0;
    // Bench state
    int          bad_count = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          since = 0;
    int          n;
    logic        g;
    logic        kick_prev = 1'b0;
    logic        rd_seen = 1'b0;
    logic [31:0] lf = 32'hB20B;
    logic [31:0] exp_q[$];             // Expected read data, oldest first

    svrw_top #(.RST_CYC(RC), .WDG_CYC(WC)) dut (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_cmp(cmp), .i_watchdog_kick(kick),
        .i_manual_reset_n(mr_n), .i_chip_enable_in(ce_in), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_reset_n(rst_n), .o_reset(rst), .o_supply_low_warning_n(warn_n),
        .o_watchdog_fault_n(fault_n), .o_chip_enable_gated(gated),
        .o_backup_active(bkp), .o_backup_cell_good(cok));

    svrw_cpu_model #(.GAP(10)) cpu (
        .i_mclk(i_mclk), .i_reset_n(rst_n), .i_fault_n(fault_n), .i_kick_run(kick_run),
        .i_slow(slow), .i_wire_fault(wire_f), .i_button_n(button_n), .i_ce_drive(ce_drive),
        .o_watchdog_kick(kick), .o_manual_reset_n(mr_n), .o_chip_enable_in(ce_in));

    // 125 MHz clock
    initial begin
        forever #4 i_mclk = ~i_mclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Let k edges pass, then sample settled outputs
    task automatic tick(input int k);
        repeat (k) @(posedge i_mclk);
        #1;
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask

    // Expected data is queued for the watcher
    task automatic bus_rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        exp_q.push_back(exp);
        @(posedge i_mclk);
        i_rd   <= 1'b0;
    endtask

    // Cause was cleared at the last edge: count edges to release
    task automatic release_wait(input string nm);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (rst_n !== 1'b1 && n < 200);
        check(nm, n, RC + 3);
    endtask

    // Bounded wait for a fault level
    task automatic wait_fault(input logic v);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (fault_n !== v && n < 2 * WC + 60);
    endtask

    // Watcher: read data, reset pairing, kick age, hang limit
    always @(posedge i_mclk) begin
        if (rd_seen) begin
            check("rdata", o_rdata, exp_q.pop_front());
        end
        if (i_nrst) begin
            check("reset_pair", rst ^ rst_n, 1);
        end
        rd_seen   <= i_rd;
        since     <= (kick !== kick_prev) ? 0 : since + 1;
        kick_prev <= kick;
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (2) @(posedge i_mclk);
        i_nrst <= 1'b1;
        // Power-up: enable line wanders but the gate stays shut
        tick(10);
        check("por_reset", rst_n, 0);
        check("por_gate", gated, 1);
        check("por_warn", warn_n, 0);
        // Supply rises, dips mid-timeout, rises again
        @(posedge i_mclk);
        cmp.below_rst <= 1'b0;
        cmp.low_line  <= 1'b0;
        tick(RC / 2);
        @(posedge i_mclk);
        cmp.below_rst <= 1'b1;
        @(posedge i_mclk);
        cmp.below_rst <= 1'b0;
        release_wait("dip_restart");
        // Gate passes random enable levels
        kick_run <= 1'b1;
        repeat (8) begin
            @(posedge i_mclk);
            lf = lfsr(lf);
            ce_drive <= lf[0];
            tick(4);
            check("ce_pass", gated, lf[0]);
        end
        // Register map, unmapped place ignored
        bus_rd(4'h0, 32'h1);
        bus_rd(4'h4, 32'h3B);
        bus_wr(4'h8, 32'hFFFF_FFFF);
        bus_rd(4'h8, 32'h0);
        bus_rd(4'h0, 32'h1);
        // Slow firmware still keeps the watchdog quiet
        slow <= 1'b1;
        tick(3 * WC);
        check("wdg_quiet", fault_n, 1);
        // Firmware stalls: fault after the full timeout, then holds
        kick_run <= 1'b0;
        wait_fault(1'b0);
        check("wdg_time", since >= WC && since <= WC + 5, 1);
        tick(WC);
        check("wdg_hold", fault_n, 0);
        // Open kick input silences the fault
        @(posedge i_mclk);
        cmp.kick_open <= 1'b1;
        tick(5);
        check("wdg_open", fault_n, 1);
        // Kicks resume: no fault after the next edge
        @(posedge i_mclk);
        cmp.kick_open <= 1'b0;
        kick_run      <= 1'b1;
        tick(2 * WC);
        check("wdg_kick", fault_n, 1);
        // Watchdog switched off in the control register
        bus_wr(4'h0, 32'h0);
        kick_run <= 1'b0;
        tick(2 * WC);
        check("wdg_off", fault_n, 1);
        bus_rd(4'h0, 32'h0);
        bus_wr(4'h0, 32'h1);
        // Fault wired into the reset switch gives a reset
        wire_f <= 1'b1;
        wait_fault(1'b0);
        tick(5);
        check("wired_reset", rst_n, 0);
        check("fault_in_reset", fault_n, 1);
        check("mr_gate", gated, 1);
        wire_f   <= 1'b0;
        kick_run <= 1'b1;
        tick(RC + 20);
        check("wired_end", rst_n, 1);
        // Bouncing switch, one reset after it settles
        repeat (6) begin
            @(posedge i_mclk);
            lf = lfsr(lf);
            button_n <= lf[0];
            tick(lf[3:1]);
        end
        @(posedge i_mclk);
        button_n <= 1'b0;
        tick(10);
        check("mr_hold", rst_n, 0);
        @(posedge i_mclk);
        button_n <= 1'b1;
        release_wait("mr_release");
        // Every comparator combination except kick_open against the status outputs
        for (int i = 0; i < 32; i++) begin
            @(posedge i_mclk);
            cmp.below_backup_cell_supply <= i[0];
            cmp.low_line   <= i[1];
            cmp.cell_above <= i[2];
            cmp.ge_4v      <= i[3];
            cmp.below_rst  <= i[4];
            tick(4);
            check("backup", bkp, i[4] & i[0]);
            check("cell_good", cok, i[2] & i[3]);
            check("warn", warn_n, !(i[1] | (i[4] & i[0])));
        end
        @(posedge i_mclk);
        cmp <= 6'h06;
        release_wait("supply_back");
        // Supply loss: gate stays open for the hold, then shuts
        @(posedge i_mclk);
        cmp.below_rst <= 1'b1;
        tick(CE - 10);
        g = gated;
        tick(1);
        check("gate_late_open", gated, !g);
        tick(20);
        check("gate_shut", gated, 1);
        @(posedge i_mclk);
        cmp.below_rst <= 1'b0;
        release_wait("final_up");
        end_of_test();
    end
endmodule
`default_nettype wire
